// ### lecins_pkg.sv
// Constants and carriers for the line error count and insert block.
// Assumes a single 40 MHz clock and synchronous active-high reset.
package lecins_pkg;

  localparam logic [7:0] ADDR_CTRL = 8'h10;
  localparam logic [7:0] ADDR_MASK = 8'h12;
  localparam logic [7:0] ADDR_STAT = 8'h17;
  localparam logic [7:0] ADDR_CNTA = 8'h18;
  localparam logic [7:0] ADDR_CNTB = 8'h19;

  // Control register fields
  localparam int CTRL_ZSTD = 0;
  localparam int CTRL_MODE = 1;
  localparam int CTRL_TRF = 2;
  localparam int CTRL_SEL_LO = 3;
  localparam int CTRL_VINS = 5;
  localparam int CTRL_PINS = 6;
  // Mask and status fields
  localparam int BIT_PERR = 0;
  localparam int BIT_CV = 1;
  localparam int BIT_EXZ = 2;
  localparam int BIT_TMR = 3;
  localparam int BIT_OVF = 4;

  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'hFF;

  localparam logic [1:0] SEL_PRBS = 2'h0;
  localparam logic [1:0] SEL_CV = 2'h1;
  localparam logic [1:0] SEL_EXZ = 2'h2;
  localparam logic [1:0] SEL_BOTH = 2'h3;

  localparam logic [6:0] ZRUN_AMI_ANSI = 7'h0F;
  localparam logic [6:0] ZRUN_AMI_FCC = 7'h50;
  localparam logic [6:0] ZRUN_HDB3 = 7'h03;
  localparam logic [6:0] ZRUN_B8ZS = 7'h07;

  localparam longint CLK_HZ = 40000000;
  localparam longint SECOND_NS = 1000000000;
  localparam longint SECOND_CYC = SECOND_NS * CLK_HZ / 1000000000;

  typedef enum logic [1:0] {LCI_AMI, LCI_HDB3, LCI_B8ZS} lecins_code_t;

  // One received symbol: pulse present and its polarity
  typedef struct packed {
    logic valid;
    logic pulse;
    logic neg;
    logic subst;
    logic patErr;
  } lecins_rx_t;

  typedef struct packed {
    logic valid;
    logic one;
    logic neg;
  } lecins_tx_t;

endpackage : lecins_pkg

// ### lecins_line_error_count_insert.sv
// Line code error detect, count and insert for one channel.
// Assumes decoded receive symbols and transmit symbols arrive as valid
// strobes on clk, and a simple byte register port as the host side.
// Summary of operation
// - AMI: same-polarity successive pulses flag violation
// - HDB3/B8ZS: unsubstituted repeat violation flags code error
// - Standard select picks ANSI or FCC zero limits
// - AMI zero limit more than 15 or 80
// - HDB3 zero limit more than 3
// - B8ZS zero limit more than 7
// - Two-bit select picks error type; 11 both
// - Select 00 counts pattern logic errors
// - Errors accumulate in 16-bit internal counter
// - Each selected error type sets its status bit; mask gates interrupt
// - Mode bit 1 automatic, 0 manual report
// - Violation pin high one clock per AMI violation or HDB3/B8ZS code error, single rail only
// - One-second expiry copies count, clears, restarts
// - Errors during transfer go to next round
// - Timer expiry sets flag; mask 0 interrupts
// - Timer flag clears when status read
// - Overflow sets flag; mask gates interrupt
// - Manual: trigger rising edge copies and clears
// - Insert trigger inverts middle of three ones
// - Pattern insert trigger flips one bit
module lecins_line_error_count_insert
  import lecins_pkg::*;
#(
  parameter longint SECOND_CYCLES = SECOND_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire lecins_code_t lineCode,
  input wire logic singleRail,
  input wire lecins_rx_t rxSym,
  input wire lecins_tx_t txIn,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  output logic irqOut,
  output logic violationPulseOut,
  output lecins_tx_t txOut,
  output logic patternErrorInject
);

  logic [7:0] ctrl_ff;
  logic [7:0] mask_ff;
  logic [7:0] stat_ff;
  logic [15:0] count_ff;
  logic [15:0] snap_ff;
  logic [31:0] tick_ff;
  logic lastNeg_ff;
  logic seenPulse_ff;
  logic lastWasViol_ff;
  logic [6:0] zeros_ff;
  logic trfPrev_ff;
  logic vinsPrev_ff;
  logic pinsPrev_ff;
  logic vinsArmed_ff;
  logic [1:0] txPipeOne_ff;
  logic [1:0] txPipeNeg_ff;
  logic [1:0] txPipeVal_ff;
  logic [7:0] regRdata_ff;
  logic violPulse_ff;
  logic patInj_ff;

  logic isViol;
  logic isCodeErr;
  logic lineViol;
  logic zeroErr;
  logic countEv;
  logic tmrExp;
  logic trfEdge;
  logic doXfer;
  logic ovfEv;
  logic [1:0] sel;
  logic [6:0] zLimit;
  logic statRd;
  logic [7:0] setBits;

  function automatic logic [6:0] zeroLimit(lecins_code_t c, logic fcc);
    unique case (c)
      LCI_HDB3: zeroLimit = ZRUN_HDB3;
      LCI_B8ZS: zeroLimit = ZRUN_B8ZS;
      default: zeroLimit = fcc ? ZRUN_AMI_FCC : ZRUN_AMI_ANSI;
    endcase
  endfunction

  assign sel = ctrl_ff[CTRL_SEL_LO+1:CTRL_SEL_LO];
  assign zLimit = zeroLimit(lineCode, ctrl_ff[CTRL_ZSTD]);
  assign isViol = rxSym.valid && rxSym.pulse && seenPulse_ff &&
                  (rxSym.neg == lastNeg_ff);
  assign isCodeErr = isViol && !rxSym.subst && lastWasViol_ff;
  assign lineViol = (lineCode == LCI_AMI) ? isViol : isCodeErr;
  assign zeroErr = rxSym.valid && !rxSym.pulse &&
                   (zeros_ff == zLimit);

  always_comb begin
    unique case (sel)
      SEL_PRBS: countEv = rxSym.valid && rxSym.patErr;
      SEL_CV: countEv = lineViol;
      SEL_EXZ: countEv = zeroErr;
      SEL_BOTH: countEv = lineViol || zeroErr;
    endcase
  end

  assign tmrExp = ctrl_ff[CTRL_MODE] &&
                  (tick_ff == 32'(SECOND_CYCLES - 1));
  assign trfEdge = ctrl_ff[CTRL_TRF] && !trfPrev_ff;
  assign doXfer = tmrExp || (!ctrl_ff[CTRL_MODE] && trfEdge);
  assign ovfEv = countEv && (count_ff == 16'hFFFF) && !doXfer;
  assign statRd = regRd && (regAddr == ADDR_STAT);

  always_comb begin
    setBits = 8'h00;
    setBits[BIT_PERR] = rxSym.valid && rxSym.patErr && (sel == SEL_PRBS);
    setBits[BIT_CV] = lineViol && sel[0];
    setBits[BIT_EXZ] = zeroErr && sel[1];
    setBits[BIT_TMR] = tmrExp;
    setBits[BIT_OVF] = ovfEv;
  end

  // Line history
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lastNeg_ff <= 1'b0;
      seenPulse_ff <= 1'b0;
      lastWasViol_ff <= 1'b0;
      zeros_ff <= 7'h00;
    end else if (rxSym.valid) begin
      if (rxSym.pulse) begin
        lastNeg_ff <= rxSym.neg;
        seenPulse_ff <= 1'b1;
        lastWasViol_ff <= isViol && !rxSym.subst;
        zeros_ff <= 7'h00;
      end else if (zeros_ff != 7'h7F) begin
        zeros_ff <= zeros_ff + 7'h01;
      end
    end
  end

  // One-second period timer
  always_ff @(posedge clk) begin
    if (sys_rst || !ctrl_ff[CTRL_MODE] || tmrExp) begin
      tick_ff <= 32'h0000_0000;
    end else begin
      tick_ff <= tick_ff + 32'h0000_0001;
    end
  end

  // Error counter; event in transfer cycle starts new round
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count_ff <= 16'h0000;
      snap_ff <= 16'h0000;
    end else if (doXfer) begin
      snap_ff <= count_ff;
      count_ff <= countEv ? 16'h0001 : 16'h0000;
    end else if (countEv && count_ff != 16'hFFFF) begin
      count_ff <= count_ff + 16'h0001;
    end
  end

  // Sticky status, set beats clear-on-read
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stat_ff <= 8'h00;
    end else begin
      stat_ff <= (statRd ? 8'h00 : stat_ff) | setBits;
    end
  end

  assign irqOut = |(stat_ff & ~mask_ff);

  // Register writes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_ff <= CTRL_RST;
      mask_ff <= MASK_RST;
    end else if (regWr) begin
      if (regAddr == ADDR_CTRL) begin
        ctrl_ff <= regWdata;
      end
      if (regAddr == ADDR_MASK) begin
        mask_ff <= regWdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      trfPrev_ff <= 1'b0;
      vinsPrev_ff <= 1'b0;
      pinsPrev_ff <= 1'b0;
    end else begin
      trfPrev_ff <= ctrl_ff[CTRL_TRF];
      vinsPrev_ff <= ctrl_ff[CTRL_VINS];
      pinsPrev_ff <= ctrl_ff[CTRL_PINS];
    end
  end

  // Register reads
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      regRdata_ff <= 8'h00;
    end else if (regRd) begin
      unique case (regAddr)
        ADDR_CTRL: regRdata_ff <= ctrl_ff;
        ADDR_MASK: regRdata_ff <= mask_ff;
        ADDR_STAT: regRdata_ff <= stat_ff;
        ADDR_CNTA: regRdata_ff <= snap_ff[7:0];
        ADDR_CNTB: regRdata_ff <= snap_ff[15:8];
        default: regRdata_ff <= 8'h00;
      endcase
    end
  end
  assign regRdata = regRdata_ff;

  // Violation pin
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      violPulse_ff <= 1'b0;
    end else begin
      violPulse_ff <= singleRail && lineViol;
    end
  end
  assign violationPulseOut = violPulse_ff;

  // Transmit insertion: two-stage delay to see three ones
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      vinsArmed_ff <= 1'b0;
      txPipeOne_ff <= 2'h0;
      txPipeNeg_ff <= 2'h0;
      txPipeVal_ff <= 2'h0;
      txOut <= '0;
    end else begin
      if (ctrl_ff[CTRL_VINS] && !vinsPrev_ff) begin
        vinsArmed_ff <= 1'b1;
      end
      if (txIn.valid) begin
        txPipeOne_ff <= {txPipeOne_ff[0], txIn.one};
        txPipeNeg_ff <= {txPipeNeg_ff[0], txIn.neg};
        txPipeVal_ff <= {txPipeVal_ff[0], 1'b1};
        if (vinsArmed_ff && txIn.one && (&txPipeOne_ff)) begin
          vinsArmed_ff <= 1'b0;
          txPipeNeg_ff <= {~txPipeNeg_ff[0], txIn.neg};
        end
      end
      txOut.valid <= txIn.valid && txPipeVal_ff[1];
      txOut.one <= txPipeOne_ff[1];
      txOut.neg <= txPipeNeg_ff[1];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      patInj_ff <= 1'b0;
    end else begin
      patInj_ff <= ctrl_ff[CTRL_PINS] && !pinsPrev_ff;
    end
  end
  assign patternErrorInject = patInj_ff;

  property p_viol_pin;
    @(posedge clk) disable iff (sys_rst)
      (singleRail && lineViol) |=> violationPulseOut;
  endproperty
  a_viol_pin: assert property (p_viol_pin) else $error("no pin");

  property p_xfer_clear;
    @(posedge clk) disable iff (sys_rst)
      (doXfer && !countEv) |=> (count_ff == 16'h0000);
  endproperty
  a_xfer_clear: assert property (p_xfer_clear) else $error("no clr");

  property p_xfer_keep;
    @(posedge clk) disable iff (sys_rst)
      (doXfer && countEv) |=> (count_ff == 16'h0001);
  endproperty
  a_xfer_keep: assert property (p_xfer_keep) else $error("lost");

  property p_snap;
    @(posedge clk) disable iff (sys_rst)
      doXfer |=> (snap_ff == $past(count_ff));
  endproperty
  a_snap: assert property (p_snap) else $error("bad snap");

  property p_sat;
    @(posedge clk) disable iff (sys_rst)
      (count_ff == 16'hFFFF && !doXfer) |=> (count_ff == 16'hFFFF);
  endproperty
  a_sat: assert property (p_sat) else $error("wrapped");

  property p_tmr_flag;
    @(posedge clk) disable iff (sys_rst)
      tmrExp |=> stat_ff[BIT_TMR];
  endproperty
  a_tmr_flag: assert property (p_tmr_flag) else $error("no tmr");

  property p_rd_clr;
    @(posedge clk) disable iff (sys_rst)
      (statRd && !tmrExp) |=> !stat_ff[BIT_TMR];
  endproperty
  a_rd_clr: assert property (p_rd_clr) else $error("no rdclr");

  property p_ovf;
    @(posedge clk) disable iff (sys_rst)
      ovfEv |=> stat_ff[BIT_OVF];
  endproperty
  a_ovf: assert property (p_ovf) else $error("no ovf");

  property p_count;
    @(posedge clk) disable iff (sys_rst)
      (countEv && !doXfer && count_ff != 16'hFFFF) |=>
        (count_ff == $past(count_ff) + 16'h0001);
  endproperty
  a_count: assert property (p_count) else $error("no cnt");

  // Armed and three marks in a row on the transmit side
  sequence s_three_marks;
    vinsArmed_ff && txIn.valid && txIn.one && (&txPipeOne_ff);
  endsequence

  property p_ins_flip;
    @(posedge clk) disable iff (sys_rst)
      s_three_marks |=>
        (txPipeNeg_ff[1] != $past(txPipeNeg_ff[0])) && !vinsArmed_ff;
  endproperty
  a_ins_flip: assert property (p_ins_flip) else $error("no flip");

  property p_pat_once;
    @(posedge clk) disable iff (sys_rst)
      patternErrorInject |=> !patternErrorInject;
  endproperty
  a_pat_once: assert property (p_pat_once) else $error("inj held");

  property p_rail_off;
    @(posedge clk) disable iff (sys_rst)
      !singleRail |=> !violationPulseOut;
  endproperty
  a_rail_off: assert property (p_rail_off) else $error("pin on");

endmodule // lecins_line_error_count_insert

// ### lecins_rx_model.sv
// Behavioural receive decoder feeding one symbol every two cycles, or one per cycle in a burst.
// Assumes callers are aligned just after a rising clk edge.
module lecins_rx_model
  import lecins_pkg::*;
(
  input wire logic clk,
  output lecins_rx_t rxSym
);
  initial rxSym = '0;

  // Fields show inverted values once valid is released
  task automatic send(input logic p, input logic n, input logic s,
                      input logic e);
    rxSym <= '{1'b1, p, n, s, e};
    @(posedge clk);
    rxSym <= '{1'b0, ~p, ~n, ~s, ~e};
    @(posedge clk);
  endtask

  // Pattern errors on n back-to-back symbols
  task automatic burst(input int n);
    rxSym <= '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
    repeat (n) @(posedge clk);
    rxSym <= '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
    @(posedge clk);
  endtask
endmodule // lecins_rx_model

// ### lecins_line_error_count_insert_bench.sv
// Self-checking bench for the line error count and insert block.
// Assumes the receive model above and a 100-cycle second.
module lecins_line_error_count_insert_bench
  import lecins_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, sys_rst = 1, singleRail = 1, regWr = 0, regRd = 0, pol = 0;
  lecins_code_t lineCode = LCI_AMI;
  lecins_tx_t txIn = '0;
  lecins_tx_t txOut;
  lecins_rx_t rxSym;
  logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata, rd8;
  logic irqOut, violationPulseOut, patternErrorInject;
  int bad_count = 0, samples_checked = 0, vioSeen = 0, injSeen = 0;
  lecins_code_t zc[4] = '{LCI_AMI, LCI_AMI, LCI_HDB3, LCI_B8ZS};
  logic [7:0] zctl[4] = '{8'h10, 8'h11, 8'h11, 8'h10};
  logic [6:0] zlim[4] = '{ZRUN_AMI_ANSI, ZRUN_AMI_FCC, ZRUN_HDB3, ZRUN_B8ZS};
  logic [2:0] txExp[5] = '{3'h6, 3'h6, 3'h6, 3'h7, 3'h2};

  lecins_line_error_count_insert #(.SECOND_CYCLES(100))
    lecins_line_error_count_insert_i (.clk(clk), .sys_rst(sys_rst),
    .lineCode(lineCode), .singleRail(singleRail), .rxSym(rxSym),
    .txIn(txIn), .regWr(regWr), .regRd(regRd), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata), .irqOut(irqOut),
    .violationPulseOut(violationPulseOut), .txOut(txOut),
    .patternErrorInject(patternErrorInject));
  lecins_rx_model lecins_rx_model_i (.clk(clk), .rxSym(rxSym));

  initial forever #12.5 clk = ~clk;
  always @(posedge clk) begin
    if (violationPulseOut === 1'b1) vioSeen++;
    if (patternErrorInject === 1'b1) injSeen++;
  end

  task automatic close_out();
    if (bad_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRdata;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    check({8'h00, d}, {8'h00, exp});
  endtask
  task automatic zeros(input int n);
    repeat (n) lecins_rx_model_i.send(1'b0, 1'b0, 1'b0, 1'b0);
  endtask
  task automatic wait_tmr();
    logic [7:0] d;
    for (int i = 0; i < 60; i++) begin
      rd(ADDR_STAT, d);
      if (d[BIT_TMR] === 1'b1) return;
    end
    bad_count++;
    close_out();
  endtask

  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rdc(ADDR_MASK, MASK_RST);
    rdc(ADDR_CTRL, CTRL_RST);
    rdc(8'h33, 8'h00);
    wr(ADDR_STAT, 8'hFF);
    rdc(ADDR_STAT, 8'h00);
    // Three same-polarity repeats in AMI
    wr(ADDR_CTRL, 8'h08);
    wr(ADDR_MASK, 8'hFD);
    repeat (4) lecins_rx_model_i.send(1'b1, 1'b0, 1'b0, 1'b0);
    @(posedge clk);
    #1;
    check(16'(vioSeen), 16'h0003);
    check({15'h0000, irqOut}, 16'h0001);
    @(posedge clk);
    rdc(ADDR_STAT, 8'h02);
    rdc(ADDR_STAT, 8'h00);
    wr(ADDR_CTRL, 8'h0C);
    repeat (2) @(posedge clk);
    rdc(ADDR_CNTA, 8'h03);
    rdc(ADDR_CNTB, 8'h00);
    wr(ADDR_CTRL, 8'h08);
    wr(ADDR_CTRL, 8'h0C);
    repeat (2) @(posedge clk);
    rdc(ADDR_CNTA, 8'h00);
    // HDB3: repeated violation counts, substituted pulse does not
    lineCode <= LCI_HDB3;
    singleRail <= 1'b0;
    wr(ADDR_CTRL, 8'h08);
    repeat (3) lecins_rx_model_i.send(1'b1, 1'b1, 1'b0, 1'b0);
    lecins_rx_model_i.send(1'b1, 1'b1, 1'b1, 1'b0);
    lecins_rx_model_i.send(1'b1, 1'b1, 1'b0, 1'b0);
    wr(ADDR_CTRL, 8'h0C);
    repeat (2) @(posedge clk);
    rdc(ADDR_CNTA, 8'h01);
    check(16'(vioSeen), 16'h0003);
    rdc(ADDR_STAT, 8'h02);
    lineCode <= LCI_AMI;
    singleRail <= 1'b1;
    // Pattern errors counted with select 00
    wr(ADDR_CTRL, 8'h00);
    repeat (2) lecins_rx_model_i.send(1'b0, 1'b0, 1'b0, 1'b1);
    wr(ADDR_CTRL, 8'h04);
    repeat (2) @(posedge clk);
    rdc(ADDR_CNTA, 8'h02);
    rdc(ADDR_STAT, 8'h01);
    for (int i = 0; i < 4; i++) begin
      lineCode <= zc[i];
      wr(ADDR_CTRL, zctl[i]);
      pol = ~pol;
      lecins_rx_model_i.send(1'b1, pol, 1'b0, 1'b0);
      zeros(int'(zlim[i]));
      rdc(ADDR_STAT, 8'h00);
      zeros(1);
      rdc(ADDR_STAT, 8'h04);
    end
    lineCode <= LCI_AMI;
    wr(ADDR_CTRL, 8'h40);
    repeat (2) @(posedge clk);
    check(16'(injSeen), 16'h0001);
    // Arm violation insert, then send marks of alternating polarity
    wr(ADDR_CTRL, 8'h20);
    for (int i = 0; i < 8; i++) begin
      txIn <= '{i < 6, 1'b1, i[0]};
      @(posedge clk);
      if (i >= 3) check({13'h0000, txOut}, {13'h0000, txExp[i-3]});
    end
    txIn <= '0;
    // Pattern errors every cycle until the counter saturates
    lecins_rx_model_i.burst(65535);
    wr(ADDR_CTRL, 8'h04);
    repeat (2) @(posedge clk);
    rdc(ADDR_CNTA, 8'hFF);
    rdc(ADDR_CNTB, 8'hFF);
    rdc(ADDR_STAT, 8'h11);
    // Errors in the transfer cycle carry into the next round
    wr(ADDR_CTRL, 8'h00);
    fork
      lecins_rx_model_i.burst(6);
      wr(ADDR_CTRL, 8'h04);
    join
    rdc(ADDR_CNTA, 8'h01);
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_CTRL, 8'h04);
    repeat (2) @(posedge clk);
    rdc(ADDR_CNTA, 8'h05);
    // Automatic mode: two repeats inside one second
    wr(ADDR_CTRL, 8'h0A);
    wait_tmr();
    repeat (3) lecins_rx_model_i.send(1'b1, ~pol, 1'b0, 1'b0);
    wait_tmr();
    rdc(ADDR_CNTA, 8'h02);
    rdc(ADDR_CNTB, 8'h00);
    wr(ADDR_MASK, 8'hF7);
    for (int i = 0; i < 120 && irqOut !== 1'b1; i++) @(posedge clk);
    check({15'h0000, irqOut}, 16'h0001);
    close_out();
  end
endmodule // lecins_line_error_count_insert_bench
